// [wake_pkg.sv]
/*
 * Package for the wake input monitor: power mode codes, bias codes,
 * filter timing and carrier structs.
 * Assumes a 200 MHz core clock.
 */
package wake_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 200;
    localparam int WAKE_FILTER_TIME_US = 16;
    localparam int FILTER_CYCLES = WAKE_FILTER_TIME_US * CLK_FREQ_MHZ;
    localparam int FILTER_CNT_W = 13;
    localparam logic [FILTER_CNT_W-1:0] FILTER_LAST =
        FILTER_CNT_W'(FILTER_CYCLES - 1);
    localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_RST = 13'h0000;

    // ------------------------------------------------------------
    // Power modes and bias codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL    = 3'h0,
        MODE_STOP      = 3'h1,
        MODE_SLEEP     = 3'h2,
        MODE_FAIL_SAFE = 3'h3,
        MODE_OTHER     = 3'h4
    } power_mode_e;

    localparam logic [1:0] BIAS_NONE = 2'h0;
    localparam logic [1:0] BIAS_PULL_DOWN = 2'h1;
    localparam logic [1:0] BIAS_PULL_UP = 2'h2;
    localparam logic [1:0] BIAS_AUTO = 2'h3;
    localparam logic [1:0] BIAS_RST = BIAS_NONE;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wake_input_enable;
        logic buck_mode_select_by_wake;
        logic cyclic_sense;
        logic bias_select_high;
        logic bias_select_low;
    } wake_cfg_s;

    typedef struct packed {
        logic irq_req;
        logic wake_req;
        logic restart_req;
        logic pwm_select;
        logic pull_up_en;
        logic pull_down_en;
        logic wake_level;
        logic wake_pin_event_flag;
    } wake_out_s;

endpackage

// [wake_filter.sv]
/*
 * Stability filter: a new level is accepted only after it held for the
 * full filter time; shorter glitches are dropped.
 * Assumes a synchronous input and a clock enable from the parent.
 */
`timescale 1ns/1ps
module wake_filter
    import wake_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Sample path
    input wire logic sample_en_in,
    input wire logic level_in,
    // Filtered result
    output logic level_out,
    output logic edge_out
);

    typedef struct packed {
        logic [FILTER_CNT_W-1:0] cnt;
        logic level;
        logic edge_p;
    } filt_state_s;

    filt_state_s st_r;
    filt_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.edge_p = 1'b0;
        if (!sample_en_in || level_in == st_r.level) begin
            st_nxt.cnt = FILTER_CNT_RST;
        end else if (st_r.cnt == FILTER_LAST) begin
            st_nxt.cnt = FILTER_CNT_RST;
            st_nxt.level = level_in;
            st_nxt.edge_p = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.level;
    assign edge_out = st_r.edge_p;

endmodule

// [wake_input_monitor.sv]
/*
 * Wake input monitor top: filtered edge detection on the wake pin,
 * mode-dependent interrupt / wake / restart requests, sticky event flag,
 * live level in normal and stop modes, buck modulation select and bias control.
 * Assumes the pin is synchronous to clk_in and the power mode and
 * cyclic sense window come from the mode controller.
 */
`timescale 1ns/1ps
module wake_input_monitor
    import wake_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Wake pin and mode context
    input wire logic wake_pin_in,
    input wire power_mode_e power_mode_in,
    input wire logic sense_window_in,
    // Configuration
    input wire wake_cfg_s cfg_in,
    input wire logic flag_clear_in,
    // Results
    output wake_out_s out_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        wake_out_s o;
        logic [FILTER_CNT_W-1:0] diff_run;
    } top_state_s;

    top_state_s st_r;
    top_state_s st_nxt;

    logic sample_en;
    logic filt_level;
    logic filt_edge;
    logic [1:0] bias_code;
    logic mode_active;
    logic event_ok;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    // Static sense samples always, cyclic only in window
    assign sample_en = !cfg_in.cyclic_sense || sense_window_in;

    wake_filter u_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .sample_en_in(sample_en),
        .level_in(wake_pin_in),
        .level_out(filt_level),
        .edge_out(filt_edge)
    );

    assign bias_code = {cfg_in.bias_select_high, cfg_in.bias_select_low};
    assign mode_active = (power_mode_in == MODE_NORMAL) || (power_mode_in == MODE_STOP);
    assign event_ok = filt_edge && cfg_in.wake_input_enable;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.o.irq_req = 1'b0;
        st_nxt.o.wake_req = 1'b0;
        st_nxt.o.restart_req = 1'b0;
        case (power_mode_in)
            MODE_NORMAL, MODE_STOP: begin
                st_nxt.o.irq_req = event_ok;
            end
            MODE_SLEEP: begin
                st_nxt.o.wake_req = event_ok;
            end
            MODE_FAIL_SAFE: begin
                st_nxt.o.wake_req = filt_edge;
                st_nxt.o.restart_req = filt_edge;
            end
            default: begin
            end
        endcase
        // Set wins over clear
        if (flag_clear_in) begin
            st_nxt.o.wake_pin_event_flag = 1'b0;
        end
        if ((power_mode_in == MODE_FAIL_SAFE) ? filt_edge : event_ok) begin
            st_nxt.o.wake_pin_event_flag = 1'b1;
        end
        if (mode_active) begin
            st_nxt.o.wake_level = filt_level;
        end
        if (cfg_in.buck_mode_select_by_wake && power_mode_in == MODE_STOP) begin
            st_nxt.o.pwm_select = wake_pin_in;
        end
        // Shadow run of differing samples, read only by the filter check
        if (sample_en && wake_pin_in != filt_level) begin
            st_nxt.diff_run = st_r.diff_run + 13'h0001;
        end else begin
            st_nxt.diff_run = FILTER_CNT_RST;
        end
        case (bias_code)
            BIAS_NONE: begin
                st_nxt.o.pull_up_en = 1'b0;
                st_nxt.o.pull_down_en = 1'b0;
            end
            BIAS_PULL_DOWN: begin
                st_nxt.o.pull_up_en = 1'b0;
                st_nxt.o.pull_down_en = 1'b1;
            end
            BIAS_PULL_UP: begin
                st_nxt.o.pull_up_en = 1'b1;
                st_nxt.o.pull_down_en = 1'b0;
            end
            BIAS_AUTO: begin
                st_nxt.o.pull_up_en = wake_pin_in;
                st_nxt.o.pull_down_en = !wake_pin_in;
            end
            default: begin
                st_nxt.o.pull_up_en = 1'b0;
                st_nxt.o.pull_down_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    assign out_out = st_r.o;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_irq_needs_enable: assert property (clk_en_in && filt_edge && !cfg_in.wake_input_enable
        |=> !out_out.irq_req) else $error("irq without enable");
    a_irq_in_active: assert property (clk_en_in && event_ok && mode_active
        |=> out_out.irq_req && !out_out.wake_req) else $error("irq missing");
    a_sleep_wake: assert property (clk_en_in && event_ok && power_mode_in == MODE_SLEEP
        |=> out_out.wake_req && !out_out.irq_req) else $error("sleep wake missing");
    a_failsafe_restart: assert property (clk_en_in && filt_edge
        && power_mode_in == MODE_FAIL_SAFE |=> out_out.restart_req)
        else $error("restart missing");
    a_flag_sticky: assert property (clk_en_in && out_out.wake_pin_event_flag && !flag_clear_in
        |=> out_out.wake_pin_event_flag) else $error("flag lost");
    a_flag_set: assert property (clk_en_in && event_ok
        |=> out_out.wake_pin_event_flag) else $error("flag not set");
    a_pwm_direct: assert property (clk_en_in && cfg_in.buck_mode_select_by_wake
        && power_mode_in == MODE_STOP |=> out_out.pwm_select == $past(wake_pin_in))
        else $error("pwm select wrong");
    a_bias_auto: assert property (clk_en_in && bias_code == BIAS_AUTO
        |=> out_out.pull_up_en == $past(wake_pin_in) && out_out.pull_down_en != out_out.pull_up_en)
        else $error("auto bias wrong");
    a_bias_none: assert property (clk_en_in && bias_code == BIAS_NONE
        |=> !out_out.pull_up_en && !out_out.pull_down_en) else $error("bias none wrong");
    a_window_gate: assert property (clk_en_in && cfg_in.cyclic_sense && !sense_window_in
        |=> !filt_edge) else $error("edge outside window");
    a_glitch_drop: assert property (clk_en_in && $changed(filt_level) |->
        $past(wake_pin_in) == filt_level) else $error("level not from pin");

    a_filter_time: assert property (filt_edge
        |-> st_r.diff_run == FILTER_LAST + 13'h0001) else $error("filter time wrong");
    a_clear_flag: assert property (clk_en_in && flag_clear_in && !filt_edge
        |=> !out_out.wake_pin_event_flag) else $error("flag not cleared");
    a_other_quiet: assert property (clk_en_in && power_mode_in == MODE_OTHER
        |=> !out_out.irq_req && !out_out.wake_req && !out_out.restart_req)
        else $error("request in other mode");
    a_level_hold: assert property (clk_en_in && !mode_active
        |=> $stable(out_out.wake_level)) else $error("level changed");
    a_level_follow: assert property (clk_en_in && mode_active
        |=> out_out.wake_level == $past(filt_level)) else $error("level stale");
    a_freeze_hold: assert property (!clk_en_in
        |=> $stable(out_out)) else $error("state moved while frozen");
    a_bias_down: assert property (clk_en_in && bias_code == BIAS_PULL_DOWN
        |=> !out_out.pull_up_en && out_out.pull_down_en) else $error("pull-down wrong");
    a_bias_up: assert property (clk_en_in && bias_code == BIAS_PULL_UP
        |=> out_out.pull_up_en && !out_out.pull_down_en) else $error("pull-up wrong");
    a_irq_single: assert property (clk_en_in && out_out.irq_req
        |=> !out_out.irq_req) else $error("irq too long");

    c_irq: cover property (out_out.irq_req);
    c_auto_bias: cover property (bias_code == BIAS_AUTO && out_out.pull_up_en);
    c_wake: cover property (out_out.wake_req);
    c_restart: cover property (out_out.restart_req);
    c_clear_set: cover property (flag_clear_in && event_ok && clk_en_in);

endmodule

// [wake_source.sv]
/*
 * Far-side model of the wake pin: an external switch or controller output.
 * Assumes the bench clock; when released the pin follows the bias, or
 * toggles every cycle when no current source is on.
 */
`timescale 1ns/1ps
module wake_source (
    // Clock
    input wire logic clk_in,
    // Drive request
    input wire logic drive_en_in,
    input wire logic level_in,
    // Bias from the block
    input wire logic pull_up_in,
    input wire logic pull_down_in,
    // Pin
    output logic pin_out
);
    logic float_r = 1'b0;
    always_ff @(posedge clk_in) begin
        float_r <= ~float_r;
    end
    always_comb begin
        if (drive_en_in) begin
            pin_out = level_in;
        end else if (pull_up_in) begin
            pin_out = 1'b1;
        end else if (pull_down_in) begin
            pin_out = 1'b0;
        end else begin
            pin_out = float_r;
        end
    end
endmodule

// [tb_top.sv]
/*
 * Self-checking bench for the wake input monitor.
 * Assumes the 3200-cycle filter of the package and a 200 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top
    import wake_pkg::*;
;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    power_mode_e power_mode_in = MODE_NORMAL;
    logic sense_window_in = 1'b0;
    wake_cfg_s cfg_in = '0;
    logic flag_clear_in = 1'b0;
    logic drive_en = 1'b1;
    logic drive_level = 1'b0;
    logic wake_pin;
    wake_out_s out_out;
    wake_out_s seen;
    int err_count = 0;
    int n_compared = 0;
    int n;

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    wake_source src_u (.clk_in(clk_in), .drive_en_in(drive_en), .level_in(drive_level),
        .pull_up_in(out_out.pull_up_en), .pull_down_in(out_out.pull_down_en),
        .pin_out(wake_pin));
    wake_input_monitor dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .wake_pin_in(wake_pin), .power_mode_in(power_mode_in),
        .sense_window_in(sense_window_in), .cfg_in(cfg_in),
        .flag_clear_in(flag_clear_in), .out_out(out_out));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    // Sets the pin and counts edges until a request pulse, 0 if none
    task automatic transit(input logic lvl);
        n = 0;
        seen = '0;
        drive_level = lvl;
        for (int i = 1; i <= 3300 && n == 0; i++) begin
            step();
            if (|out_out[7:5] !== 1'b0) begin
                n = i;
                seen = out_out;
            end
        end
    endtask
    task automatic expect_event(input logic lvl);
        transit(lvl);
        `CHK(n, 3201)
        if (n == 0) begin
            close_out();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_normal();
        cfg_in.wake_input_enable = 1'b1;
        expect_event(1'b1);
        `CHK(seen.irq_req, 1'b1)
        `CHK(seen.wake_req, 1'b0)
        `CHK(seen.wake_level, 1'b1)
        `CHK(seen.wake_pin_event_flag, 1'b1)
        expect_event(1'b0);
        `CHK(seen.irq_req, 1'b1)
        `CHK(seen.wake_level, 1'b0)
        `CHK(seen.wake_pin_event_flag, 1'b1)
        flag_clear_in = 1'b1;
        step();
        flag_clear_in = 1'b0;
        step();
        `CHK(out_out.wake_pin_event_flag, 1'b0)
    endtask
    task automatic s_glitch();
        drive_level = 1'b1;
        repeat (3000) step();
        transit(1'b0);
        `CHK(n, 0)
    endtask
    task automatic s_disabled();
        cfg_in.wake_input_enable = 1'b0;
        transit(1'b1);
        `CHK(n, 0)
        `CHK(out_out.wake_pin_event_flag, 1'b0)
    endtask
    task automatic s_cyclic();
        cfg_in.wake_input_enable = 1'b1;
        cfg_in.cyclic_sense = 1'b1;
        transit(1'b0);
        `CHK(n, 0)
        sense_window_in = 1'b1;
        expect_event(1'b0);
        `CHK(seen.irq_req, 1'b1)
        cfg_in.cyclic_sense = 1'b0;
        sense_window_in = 1'b0;
    endtask
    task automatic s_low_power();
        power_mode_in = MODE_SLEEP;
        expect_event(1'b1);
        `CHK(seen.wake_req, 1'b1)
        `CHK(seen.irq_req, 1'b0)
        power_mode_in = MODE_FAIL_SAFE;
        cfg_in.wake_input_enable = 1'b0;
        expect_event(1'b0);
        `CHK(seen.restart_req, 1'b1)
        `CHK(seen.wake_req, 1'b1)
    endtask
    task automatic s_buck();
        power_mode_in = MODE_STOP;
        cfg_in.buck_mode_select_by_wake = 1'b1;
        for (int k = 0; k < 2; k++) begin
            drive_level = k[0] ^ 1'b1;
            step();
            `CHK(out_out.pwm_select, drive_level)
        end
        cfg_in.buck_mode_select_by_wake = 1'b0;
    endtask
    task automatic s_bias();
        for (int c = 0; c < 8; c++) begin
            drive_level = c[2];
            {cfg_in.bias_select_high, cfg_in.bias_select_low} = c[1:0];
            step();
            `CHK(out_out.pull_up_en, c[1:0] == 2'h2 || (c[1:0] == 2'h3 && c[2]))
            `CHK(out_out.pull_down_en, c[1:0] == 2'h1 || (c[1:0] == 2'h3 && !c[2]))
        end
    endtask

    task automatic s_clear_race();
        power_mode_in = MODE_NORMAL;
        cfg_in.wake_input_enable = 1'b1;
        drive_level = 1'b0;
        flag_clear_in = 1'b1;
        step();
        flag_clear_in = 1'b0;
        step();
        `CHK(out_out.wake_pin_event_flag, 1'b0)
        drive_level = 1'b1;
        repeat (3200) step();
        flag_clear_in = 1'b1;
        step();
        flag_clear_in = 1'b0;
        `CHK(out_out.irq_req, 1'b1)
        `CHK(out_out.wake_pin_event_flag, 1'b1)
    endtask
    task automatic s_freeze();
        {cfg_in.bias_select_high, cfg_in.bias_select_low} = 2'h1;
        flag_clear_in = 1'b1;
        step();
        flag_clear_in = 1'b0;
        drive_en = 1'b0;
        step();
        `CHK(wake_pin, 1'b0)
        seen = out_out;
        clk_en_in = 1'b0;
        repeat (3300) step();
        `CHK(out_out, seen)
        clk_en_in = 1'b1;
        power_mode_in = MODE_OTHER;
        transit(1'b0);
        `CHK(n, 0)
        `CHK(out_out.wake_pin_event_flag, 1'b1)
        `CHK(out_out.wake_level, 1'b1)
        drive_en = 1'b1;
    endtask

    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        step();
        `CHK(out_out, 8'h00)
        s_normal();
        s_glitch();
        s_disabled();
        s_cyclic();
        s_low_power();
        s_buck();
        s_bias();
        s_clear_race();
        s_freeze();
        close_out();
    end
endmodule
